// >>> design/rsss_pkg.sv
// rsss_pkg: constants, types and helpers of the reset sequencer
// assumes a 250 MHz sys_clk and an apb master with 32-bit data
// How it works
// RULE1: eight reset causes are told apart
// RULE2: defined registers forced on every true reset
// RULE3: watchdog wake-up resumes, nothing reinitialised
// RULE4: flag pattern per cause shows reset source
// RULE5: short master clear pulses are filtered out
// RULE6: master clear pin is never driven
// RULE7: supply rise makes power-on pulse, starts timeouts
// RULE8: power-up timer on rc ticks, holds reset
// RULE9: active-low enable bit selects power-up timer
// RULE10: oscillator count of 1024 after power-up timer
// RULE11: oscillator count only crystal modes, power-on/wake
// RULE12: pll lock delay follows oscillator count
// RULE13: brown-out enable bit gates brown-out logic
// RULE14: long brown-out resets, held until supply recovers
// RULE15: power-up timer restarts after brown-out recovery
// RULE16: brown-out during power-up timer restarts it
// RULE17: power-on delay, then timer, then oscillator count
// RULE18: external or rc clock modes skip timeouts; code still runs the power-up timer when it is enabled
// RULE19: timeouts ignore master clear; release starts at once
// RULE20: wake or clock switch waits count plus pll
// RULE21: flag values fixed per reset cause
// RULE22: reset loads zero; wake resumes or vectors
// RULE23: all causes merge, release synchronous after counters
// RULE24: stack resets set own flag, init registers
`default_nettype none
package rsss_pkg;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned POWER_UP_DELAY_TIMER_MS       = 72;
  localparam int unsigned PLL_MS        = 2;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYC      = POWER_UP_DELAY_TIMER_MS * CLK_MHZ * 1000;
  localparam int unsigned PLL_CYC       = PLL_MS * CLK_MHZ * 1000;
  localparam int unsigned OST_EDGES     = 1024;
  localparam int unsigned RC_DIV        = 4;
  localparam int unsigned POR_DLY_CYC   = 16;
  localparam int unsigned MASTER_CLEAR_PIN_FILT_CYC = 8;
  localparam int unsigned BOR_MIN_CYC   = 64;
  localparam int unsigned TMR_W         = 32;
  localparam int unsigned FILT_W        = 8;
  localparam int unsigned AW            = 12;
  localparam logic [AW-1:0] ADDR_STATUS = 12'h000;
  localparam logic [AW-1:0] ADDR_CFG    = 12'h004;
  localparam logic [AW-1:0] ADDR_STATE  = 12'h008;

  typedef enum logic [2:0] {
    OSC_LP = 3'h0,
    OSC_XT = 3'h1,
    OSC_HS = 3'h2,
    OSC_EC = 3'h3,
    OSC_RC = 3'h4
  } rsss_osc_t;

  typedef struct packed {
    logic      pll_en;
    rsss_osc_t osc;
    logic      bo_en;
    logic      power_up_delay_timer_en_n;
  } rsss_cfg_t;

  typedef struct packed {
    logic stk_full;
    logic stk_unf;
    logic ri_n;
    logic to_n;
    logic pd_n;
    logic por_n;
    logic bo_n;
  } rsss_flags_t;

  localparam int unsigned CFG_W   = $bits(rsss_cfg_t);
  localparam int unsigned FLAGS_W = $bits(rsss_flags_t);
  localparam logic [5:0]  CFG_RST   = 6'h0A;
  localparam logic [6:0]  FLAGS_RST = 7'h1C;

  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,
    ST_PORDLY = 8'h02,
    ST_BOR    = 8'h04,
    ST_POWER_UP_DELAY_TIMER   = 8'h08,
    ST_OST    = 8'h10,
    ST_PLL    = 8'h20,
    ST_HOLD   = 8'h40,
    ST_RUN    = 8'h80
  } rsss_st_t;

  typedef enum logic [3:0] {
    C_NONE = 4'h0, C_POR = 4'h1, C_MASTER_CLEAR_PIN_RUN = 4'h2, C_MASTER_CLEAR_PIN_SLP = 4'h3,
    C_WDT = 4'h4, C_BOR = 4'h5, C_INSTR = 4'h6, C_SFULL = 4'h7, C_SUNF = 4'h8
  } rsss_cause_t;

  typedef enum logic [1:0] {
    PC_ZERO = 2'h0,
    PC_NEXT = 2'h1,
    PC_VEC  = 2'h2
  } rsss_pc_t;

  function automatic logic is_xtal(input rsss_cfg_t c);
    return c.osc inside {OSC_LP, OSC_XT, OSC_HS};
  endfunction
endpackage : rsss_pkg
`default_nettype wire

// >>> design/rsss_sequencer.sv
// rsss_sequencer: reset cause detection and start-up time-out sequencing
// assumes detector and pin inputs are asynchronous, core strobes are on sys_clk
`default_nettype none
module rsss_sequencer
  import rsss_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_CYC,
  parameter int unsigned PLL_CYCLES  = PLL_CYC,
  parameter int unsigned OST_COUNT   = OST_EDGES
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          supply_ok,
  input  wire logic          brown_out_det,
  input  wire logic          master_clear_pin_n_i,
  output logic               master_clear_pin_n_o,
  output logic               master_clear_pin_n_oe_n,
  input  wire logic          oscillator_input_pin,
  input  wire logic          watchdog_timeout,
  input  wire logic          core_sleep,
  input  wire logic          wake_irq,
  input  wire logic          gie,
  input  wire logic          osc_switch,
  input  wire logic          reset_instr,
  input  wire logic          stack_full_req,
  input  wire logic          stack_unf_req,
  output logic               chip_reset,
  output logic               core_stall,
  output logic               reg_init,
  output logic               por_unknown,
  output logic               pc_load,
  output rsss_pc_t           pc_sel
);
  localparam int unsigned POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_TIMER_CYCLES / RC_DIV;
  localparam int unsigned PLL_TICKS  = PLL_CYCLES / RC_DIV;

  logic [3:0]        s1_q;
  logic [3:0]        s2_q;
  logic              sup_s2;
  logic              bo_s2;
  logic              master_clear_pin_s2;
  logic              osc_s2;
  logic              sup_prev_q;
  logic              osc_prev_q;
  logic              sup_rise;
  logic              osc_rise;
  logic [FILT_W-1:0] master_clear_pin_cnt_q;
  logic              master_clear_pin_low_q;
  logic [FILT_W-1:0] bor_cnt_q;
  logic              bor_trip_q;
  logic [7:0]        rc_cnt_q;
  logic              rc_tick;
  rsss_cfg_t         cfg_q;
  rsss_flags_t       flags_q;
  rsss_flags_t       flags_d;
  rsss_st_t          st_q;
  rsss_st_t          st_d;
  rsss_cause_t       cause_q;
  logic [TMR_W-1:0]  tmr_q;
  logic              adv;
  logic              tdone;
  logic              wake_q;
  logic              irqw_q;
  logic              evt_por;
  logic              evt_bor;
  logic              evt_master_clear_pin;
  logic              evt_wdt;
  logic              evt_ri;
  logic              evt_sf;
  logic              evt_su;
  logic              evt_wwake;
  logic              evt_iwake;
  logic              evt_oswitch;
  logic              any_rst;
  logic              free;
  logic              acc;
  logic              mapped;
  logic              wr_status;
  logic              wr_cfg;
  logic [31:0]       prdata_q;
  logic              reg_init_q;
  logic              por_unk_q;

  // pin is input-only for reset; nothing internal ever pulls it
  assign master_clear_pin_n_o    = 1'b1; // RULE6
  assign master_clear_pin_n_oe_n = 1'b1; // RULE6

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else begin
      s1_q <= {oscillator_input_pin, master_clear_pin_n_i, brown_out_det, supply_ok};
      s2_q <= s1_q;
    end
  end

  assign sup_s2  = s2_q[0];
  assign bo_s2   = s2_q[1];
  assign master_clear_pin_s2 = s2_q[2];
  assign osc_s2  = s2_q[3];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sup_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      sup_prev_q <= sup_s2;
      osc_prev_q <= osc_s2;
    end
  end

  assign sup_rise = sup_s2 && !sup_prev_q; // RULE7
  assign osc_rise = osc_s2 && !osc_prev_q;

  // pin must stay low a full filter window to count
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      master_clear_pin_cnt_q <= '0;
      master_clear_pin_low_q <= 1'b0;
    end else if (master_clear_pin_s2) begin
      master_clear_pin_cnt_q <= '0;
      master_clear_pin_low_q <= 1'b0;
    end else if (master_clear_pin_cnt_q == FILT_W'(MASTER_CLEAR_PIN_FILT_CYC - 1)) begin
      master_clear_pin_low_q <= 1'b1; // RULE5
    end else begin
      master_clear_pin_cnt_q <= master_clear_pin_cnt_q + 1'b1;
    end
  end

  // short dips below threshold never trip
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bor_cnt_q  <= '0;
      bor_trip_q <= 1'b0;
    end else if (!(bo_s2 && cfg_q.bo_en)) begin // RULE13
      bor_cnt_q  <= '0;
      bor_trip_q <= 1'b0;
    end else if (bor_cnt_q == FILT_W'(BOR_MIN_CYC - 1)) begin
      bor_trip_q <= 1'b1; // RULE14
    end else begin
      bor_cnt_q <= bor_cnt_q + 1'b1;
    end
  end

  // stands in for the internal rc oscillator
  always_ff @(posedge sys_clk) begin
    if (!rst_b || rc_tick) begin
      rc_cnt_q <= '0;
    end else begin
      rc_cnt_q <= rc_cnt_q + 1'b1;
    end
  end

  assign rc_tick = rc_cnt_q == 8'(RC_DIV - 1);

  always_comb begin
    free        = 1'b0;
    evt_por     = sup_rise; // RULE7
    evt_bor     = 1'b0;
    evt_master_clear_pin    = 1'b0;
    evt_wdt     = 1'b0;
    evt_ri      = 1'b0;
    evt_sf      = 1'b0;
    evt_su      = 1'b0;
    evt_wwake   = 1'b0;
    evt_iwake   = 1'b0;
    evt_oswitch = 1'b0;
    if (sup_s2 && !evt_por) begin
      evt_bor = bor_trip_q && (st_q inside {ST_POWER_UP_DELAY_TIMER, ST_OST, ST_PLL, ST_HOLD, ST_RUN}); // RULE16
      if (!evt_bor && st_q == ST_RUN) begin
        evt_master_clear_pin = master_clear_pin_low_q; // RULE1
        free     = !master_clear_pin_low_q;
      end
    end
    if (free) begin
      if (watchdog_timeout) begin
        evt_wdt   = !core_sleep;
        evt_wwake = core_sleep; // RULE3
      end else if (core_sleep) begin
        evt_iwake = wake_irq;
      end else begin
        evt_ri      = reset_instr;
        evt_sf      = !reset_instr && stack_full_req;
        evt_su      = !reset_instr && !stack_full_req && stack_unf_req;
        evt_oswitch = !reset_instr && !stack_full_req && !stack_unf_req && osc_switch;
      end
    end
  end

  assign any_rst = evt_por || evt_bor || evt_master_clear_pin || evt_wdt || evt_ri || evt_sf || evt_su; // RULE23

  always_comb begin
    adv   = 1'b0;
    tdone = 1'b0;
    unique case (st_q)
      ST_PORDLY: begin
        adv   = 1'b1;
        tdone = tmr_q == TMR_W'(POR_DLY_CYC - 1);
      end
      ST_POWER_UP_DELAY_TIMER: begin
        adv   = rc_tick; // RULE8
        tdone = rc_tick && tmr_q == TMR_W'(POWER_UP_DELAY_TIMER_TICKS - 1);
      end
      ST_OST: begin
        adv   = osc_rise; // RULE10
        tdone = osc_rise && tmr_q == TMR_W'(OST_COUNT - 1);
      end
      ST_PLL: begin
        adv   = rc_tick; // RULE12
        tdone = rc_tick && tmr_q == TMR_W'(PLL_TICKS - 1);
      end
      ST_OFF, ST_BOR, ST_HOLD, ST_RUN: ;
    endcase
  end

  always_comb begin
    st_d = st_q;
    if (!sup_s2) begin
      st_d = ST_OFF;
    end else if (evt_por) begin
      st_d = ST_PORDLY; // RULE17
    end else if (evt_bor) begin
      st_d = ST_BOR; // RULE14
    end else if (any_rst) begin
      st_d = ST_HOLD;
    end else if (evt_wwake || evt_iwake || evt_oswitch) begin
      st_d = is_xtal(cfg_q) ? ST_OST : ST_HOLD; // RULE20 RULE18 RULE11
    end else begin
      unique case (st_q)
        ST_PORDLY, ST_BOR: begin
          if ((st_q == ST_PORDLY && tdone) || (st_q == ST_BOR && !bo_s2)) begin
            if (!cfg_q.power_up_delay_timer_en_n) st_d = ST_POWER_UP_DELAY_TIMER; // RULE9 RULE15
            else st_d = is_xtal(cfg_q) ? ST_OST : ST_HOLD; // RULE18
          end
        end
        ST_POWER_UP_DELAY_TIMER: if (tdone) st_d = is_xtal(cfg_q) ? ST_OST : ST_HOLD; // RULE17
        ST_OST: if (tdone) st_d = (cfg_q.pll_en && cfg_q.osc == OSC_HS) ? ST_PLL : ST_HOLD; // RULE12
        ST_PLL: if (tdone) st_d = ST_HOLD;
        // time-outs already done; release waits only for the pin, not at all on a wake
        ST_HOLD: if (wake_q || !master_clear_pin_low_q) st_d = ST_RUN; // RULE19
        ST_OFF, ST_RUN: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q      <= ST_OFF;
      tmr_q     <= '0;
      wake_q    <= 1'b0;
      irqw_q    <= 1'b0;
      pc_load   <= 1'b0;
      pc_sel    <= PC_ZERO;
    end else begin
      st_q    <= st_d;
      pc_load <= 1'b0;
      // a restart of the same state must also reinitialise the count
      if (st_d != st_q || evt_wwake || evt_iwake || evt_oswitch) begin
        tmr_q <= '0; // RULE16
      end else begin
        tmr_q <= tmr_q + TMR_W'(adv);
      end
      if (any_rst || !sup_s2) begin
        wake_q <= 1'b0;
      end else if (evt_wwake || evt_iwake || evt_oswitch) begin
        wake_q <= 1'b1;
        irqw_q <= evt_iwake;
      end else if (st_q == ST_HOLD && st_d == ST_RUN) begin
        wake_q  <= 1'b0;
        pc_load <= 1'b1;
        if (!wake_q) pc_sel <= PC_ZERO; // RULE22
        else if (irqw_q && gie) pc_sel <= PC_VEC; // RULE22
        else pc_sel <= PC_NEXT;
      end
    end
  end

  assign chip_reset = st_q != ST_RUN && !wake_q; // RULE23 RULE8
  assign core_stall = wake_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_init_q <= 1'b0;
      por_unk_q  <= 1'b0;
      cause_q    <= C_NONE;
    end else begin
      reg_init_q <= any_rst; // RULE2 RULE24
      por_unk_q  <= evt_por; // RULE2
      if (evt_por) cause_q <= C_POR; // RULE1
      else if (evt_bor) cause_q <= C_BOR;
      else if (evt_master_clear_pin) cause_q <= core_sleep ? C_MASTER_CLEAR_PIN_SLP : C_MASTER_CLEAR_PIN_RUN;
      else if (evt_wdt) cause_q <= C_WDT;
      else if (evt_ri) cause_q <= C_INSTR;
      else if (evt_sf) cause_q <= C_SFULL;
      else if (evt_su) cause_q <= C_SUNF;
    end
  end

  assign reg_init    = reg_init_q;
  assign por_unknown = por_unk_q;

  // hardware pattern applied after the software write: hardware wins
  always_comb begin
    flags_d = flags_q;
    if (wr_status) flags_d = rsss_flags_t'(pwdata[FLAGS_W-1:0]);
    if (evt_por) begin
      {flags_d.ri_n, flags_d.to_n, flags_d.pd_n, flags_d.por_n, flags_d.bo_n} = 5'h1C; // RULE21
    end
    if (evt_bor) begin
      {flags_d.ri_n, flags_d.to_n, flags_d.pd_n} = 3'h7; // RULE21
      flags_d.bo_n = 1'b0;
    end
    if (evt_wdt) {flags_d.ri_n, flags_d.to_n, flags_d.pd_n} = 3'h5; // RULE21
    if (evt_master_clear_pin && core_sleep) {flags_d.to_n, flags_d.pd_n} = 2'h2; // RULE4
    if (evt_ri) flags_d.ri_n = 1'b0; // RULE4
    if (evt_sf) flags_d.stk_full = 1'b1; // RULE24
    if (evt_su) flags_d.stk_unf = 1'b1; // RULE24
    if (evt_wwake) {flags_d.to_n, flags_d.pd_n} = 2'h0; // RULE4
    if (evt_iwake) {flags_d.to_n, flags_d.pd_n} = 2'h2; // RULE4
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) flags_q <= rsss_flags_t'(FLAGS_RST);
    else flags_q <= flags_d;
  end

  assign acc       = psel && penable;
  assign mapped    = paddr == ADDR_STATUS || paddr == ADDR_CFG || (paddr == ADDR_STATE && !pwrite);
  assign wr_status = acc && pwrite && paddr == ADDR_STATUS;
  assign wr_cfg    = acc && pwrite && paddr == ADDR_CFG;
  assign pready    = 1'b1;
  assign pslverr   = acc && !mapped;
  assign prdata    = prdata_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) cfg_q <= rsss_cfg_t'(CFG_RST);
    else if (wr_cfg) cfg_q <= rsss_cfg_t'(pwdata[CFG_W-1:0]); // RULE9 RULE13
  end

  // captured in setup so read data is a flop in the access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == ADDR_STATUS) prdata_q <= 32'(flags_q);
      else if (paddr == ADDR_CFG) prdata_q <= 32'(cfg_q);
      else if (paddr == ADDR_STATE) prdata_q <= 32'({cause_q, st_q});
      else prdata_q <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_wake_start;
    (evt_iwake || evt_wwake) && !is_xtal(cfg_q);
  endsequence
  sequence s_fast_resume;
    st_q == ST_HOLD ##1 (st_q == ST_RUN && pc_load);
  endsequence

  property p_pin_free;
    master_clear_pin_n_oe_n && !$fell(master_clear_pin_n_o);
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("master clear pin driven"); // RULE6

  property p_por_start;
    evt_por |=> st_q == ST_PORDLY && chip_reset && por_unknown;
  endproperty
  a_por_start: assert property (p_por_start) else $error("power-on not started"); // RULE7

  property p_por_flags;
    evt_por |=> flags_q[4:0] == 5'h1C && reg_init;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong"); // RULE21

  property p_wdt_flags;
    evt_wdt |=> !flags_q.to_n && flags_q.pd_n && cause_q == C_WDT;
  endproperty
  a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog flags wrong"); // RULE21

  property p_master_clear_pin_filter;
    $rose(master_clear_pin_low_q) |-> $past(master_clear_pin_cnt_q) == MASTER_CLEAR_PIN_FILT_CYC - 1 && !$past(master_clear_pin_s2);
  endproperty
  a_master_clear_pin_filter: assert property (p_master_clear_pin_filter) else $error("short pulse taken"); // RULE5

  property p_power_up_delay_timer_restart;
    st_q == ST_POWER_UP_DELAY_TIMER && bor_trip_q && sup_s2 && !sup_rise |=> st_q == ST_BOR ##1 tmr_q == 0;
  endproperty
  a_power_up_delay_timer_restart: assert property (p_power_up_delay_timer_restart) else $error("timer not restarted"); // RULE16

  property p_ost_order;
    st_q == ST_OST && $past(st_q) != ST_OST && !wake_q |-> $past(st_q) inside {ST_PORDLY, ST_BOR, ST_POWER_UP_DELAY_TIMER};
  endproperty
  a_ost_order: assert property (p_ost_order) else $error("oscillator count out of order"); // RULE17

  property p_fast_wake;
    s_wake_start |=> s_fast_resume;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("time-out in non-crystal wake"); // RULE18

  property p_pc_zero;
    $rose(st_q == ST_RUN) && !$past(wake_q) |-> pc_load && pc_sel == PC_ZERO;
  endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("reset not at zero"); // RULE22

  property p_wake_keeps;
    evt_wwake |=> !reg_init && core_stall && !chip_reset;
  endproperty
  a_wake_keeps: assert property (p_wake_keeps) else $error("watchdog wake reset state"); // RULE3

  property p_stack_flag;
    evt_sf |=> flags_q.stk_full && reg_init && st_q == ST_HOLD;
  endproperty
  a_stack_flag: assert property (p_stack_flag) else $error("stack full flag missing"); // RULE24
endmodule // rsss_sequencer
`default_nettype wire

// >>> tb/rsss_ext_model.sv
// rsss_ext_model: supply monitors, master clear pin and crystal outside the sequencer
// assumes the bench steers supply and pin; the pin has a pull-up to the supply
`default_nettype none
module rsss_ext_model (
  input  wire logic vdd_on,
  input  wire logic vdd_dip,
  input  wire logic master_clear_pin_hold,
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  output logic      supply_ok,
  output logic      brown_out_det,
  output logic      pin_n,
  output logic      osc
);
  timeunit 1ns;
  timeprecision 100ps;

  assign supply_ok     = vdd_on;
  assign brown_out_det = vdd_on & vdd_dip;
  // released pin floats up to supply through the pull-up
  assign pin_n = !pin_oe_n ? pin_o : (vdd_on & !master_clear_pin_hold);

  // crystal only swings while powered
  initial begin
    osc = 1'b0;
    forever #5 osc = vdd_on ? ~osc : 1'b0;
  end
endmodule // rsss_ext_model
`default_nettype wire

// >>> tb/tb.sv
// tb: self-checking bench for the reset sequencer over apb and its pins
// assumes rsss_pkg and rsss_ext_model are compiled first
`default_nettype none
module tb import rsss_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 400;
  localparam int PL = 80;
  logic          sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          vdd_on, vdd_dip, master_clear_pin_hold, sup, bod, pin_n, pin_o, pin_oe_n, osc;
  logic [5:0]    ev;
  logic          core_sleep, gie, chip_reset, core_stall, reg_init, por_unknown, pc_load;
  rsss_pc_t      pc_sel, last_pc;
  int            n_errors, checked, n_pc, n_init, n_por, n;
  int            evi[7]  = '{3, 4, 5, 0, 0, 1, 1};
  logic [31:0]   est[7]  = '{32'h0000_000f, 32'h0000_005f, 32'h0000_003f, 32'h0000_0017,
                             32'h0000_0013, 32'h0000_001b, 32'h0000_001b};
  int            epc[7]  = '{0, 0, 0, 0, 1, 1, 2};
  int            eini[7] = '{1, 1, 1, 1, 0, 0, 0};
  logic [31:0]   bcfg[3] = '{32'h0000_000a, 32'h0000_002a, 32'h0000_000f};
  int            blo[3]  = '{PW, PW + PL, 0};
  int            bhi[3]  = '{3000, 3000, 20};

  rsss_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .PLL_CYCLES(PL), .OST_COUNT(8)) rsss_sequencer_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_ok(sup), .brown_out_det(bod), .master_clear_pin_n_i(pin_n),
    .master_clear_pin_n_o(pin_o), .master_clear_pin_n_oe_n(pin_oe_n),
    .oscillator_input_pin(osc), .watchdog_timeout(ev[0]), .core_sleep(core_sleep),
    .wake_irq(ev[1]), .gie(gie), .osc_switch(ev[2]), .reset_instr(ev[3]),
    .stack_full_req(ev[4]), .stack_unf_req(ev[5]), .chip_reset(chip_reset),
    .core_stall(core_stall), .reg_init(reg_init), .por_unknown(por_unknown),
    .pc_load(pc_load), .pc_sel(pc_sel));

  rsss_ext_model rsss_ext_model_inst (
    .vdd_on(vdd_on), .vdd_dip(vdd_dip), .master_clear_pin_hold(master_clear_pin_hold), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .supply_ok(sup), .brown_out_det(bod), .pin_n(pin_n), .osc(osc));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // sampled mid-cycle: the pulses are launched at the rising edge
  always @(negedge sys_clk) begin
    if (pc_load === 1'b1) begin
      n_pc++;
      last_pc = pc_sel;
    end
    if (reg_init === 1'b1) n_init++;
    if (por_unknown === 1'b1) n_por++;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, g, e);
    end
  endtask

  task automatic timeout();
    n_errors++;
    $display("MISMATCH t=%0t wait limit", $time);
    conclude();
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk32(rd, e);
    chk1(err, 1'b0);
  endtask

  task automatic fire(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev <= '0;
  endtask

  task automatic wait_pc();
    int k;
    int n0;
    n0 = n_pc;
    for (k = 0; k < 5000 && n_pc == n0; k++) @(negedge sys_clk);
    if (n_pc == n0) timeout();
  endtask

  task automatic wait_rst(input logic v);
    for (n = 0; n < 5000 && chip_reset !== v; n++) @(negedge sys_clk);
    if (n >= 5000) timeout();
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    vdd_on = 1'b0;
    vdd_dip = 1'b0;
    master_clear_pin_hold = 1'b0;
    ev = '0;
    core_sleep = 1'b0;
    gie = 1'b0;
    cyc(16);
    rst_b <= 1'b1;
    cyc(2);
    rdchk(ADDR_STATUS, 32'h0000_001c);
    rdchk(ADDR_CFG, 32'h0000_000a);
    apb(1'b0, 12'h100, '0);
    chk1(err, 1'b1);
    apb(1'b1, ADDR_STATE, 32'h0000_00ff);
    chk1(err, 1'b1);
    $display("END registers");
    vdd_on <= 1'b1;
    wait_rst(1'b0);
    chk1(n >= PW + 16, 1'b1);
    chk32(32'(n_por), 32'h0000_0001);
    chk32(32'(last_pc), 32'h0000_0000);
    rdchk(ADDR_STATUS, 32'h0000_001c);
    $display("END power_on");
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ADDR_STATUS, 32'h0000_001f);
      core_sleep <= (i >= 4);
      gie <= (i == 6);
      n = n_init;
      fire(evi[i]);
      wait_pc();
      core_sleep <= 1'b0;
      cyc(2);
      chk32(32'(last_pc), 32'(epc[i]));
      chk32(32'(n_init - n), 32'(eini[i]));
      rdchk(ADDR_STATUS, est[i]);
      chk1(chip_reset, 1'b0);
    end
    apb(1'b1, ADDR_CFG, 32'h0000_000e);
    core_sleep <= 1'b1;
    gie <= 1'b0;
    fire(1);
    wait_pc();
    core_sleep <= 1'b0;
    cyc(2);
    chk32(32'(last_pc), 32'h0000_0001);
    chk1(chip_reset, 1'b0);
    apb(1'b1, ADDR_CFG, 32'h0000_000a);
    chk1(pin_oe_n, 1'b1);
    $display("END core_events");
    n = n_pc;
    master_clear_pin_hold <= 1'b1;
    cyc(4);
    master_clear_pin_hold <= 1'b0;
    cyc(20);
    chk32(32'(n_pc - n), '0);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ADDR_STATUS, 32'h0000_001f);
      core_sleep <= (s == 1);
      master_clear_pin_hold <= 1'b1;
      cyc(40);
      chk1(chip_reset, 1'b1);
      master_clear_pin_hold <= 1'b0;
      core_sleep <= 1'b0;
      wait_pc();
      rdchk(ADDR_STATUS, s ? 32'h0000_001b : 32'h0000_001f);
    end
    $display("END master_clear");
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, ADDR_CFG, bcfg[j]);
      apb(1'b1, ADDR_STATUS, 32'h0000_001f);
      vdd_dip <= 1'b1;
      cyc(100);
      chk1(chip_reset, 1'b1);
      if (j == 0) begin
        vdd_dip <= 1'b0;
        cyc(200);
        vdd_dip <= 1'b1;
        cyc(100);
      end
      vdd_dip <= 1'b0;
      wait_rst(1'b0);
      chk1(n >= blo[j] && n <= bhi[j], 1'b1);
      rdchk(ADDR_STATUS, 32'h0000_001e);
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, ADDR_CFG, j ? 32'h0000_0008 : 32'h0000_000a);
      n = n_pc;
      vdd_dip <= 1'b1;
      cyc(j ? 200 : 20);
      vdd_dip <= 1'b0;
      cyc(20);
      chk32(32'(n_pc - n), '0);
    end
    $display("END brown_out");
    apb(1'b1, ADDR_CFG, 32'h0000_000a);
    vdd_on <= 1'b0;
    master_clear_pin_hold <= 1'b1;
    cyc(20);
    vdd_on <= 1'b1;
    cyc(1500);
    chk1(chip_reset, 1'b1);
    master_clear_pin_hold <= 1'b0;
    wait_rst(1'b0);
    chk1(n <= 15, 1'b1);
    apb(1'b0, ADDR_STATUS, '0);
    chk32(rd & 32'h0000_001f, 32'h0000_001c);
    chk32(32'(n_por), 32'h0000_0002);
    $display("END held_power_on");
    conclude();
  end
endmodule // tb
`default_nettype wire
